// >>> design/dscr_adc_filter.sv
// agreement filter on the converter result
// assumes conversion strobes come from logic on clk_sys
`timescale 1ns/1ps
`default_nettype none
module dscr_adc_filter
#(
  parameter int AGREE = dscr_pkg::DSCR_AGREE_COUNT
)
(
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       convValid,
  input  wire logic [5:0] convData,
  input  wire logic       filterOff,
  output logic [5:0]      result,
  output logic            resultValid
);
  import dscr_pkg::*;

  logic [5:0] last_r;
  logic [2:0] same_r;
  logic [2:0] same_nxt;
  logic       take;

  // run length of identical conversions, saturating
  assign same_nxt = (convData == last_r && same_r != 3'd0) ?
                    ((same_r == 3'(AGREE)) ? same_r : same_r + 3'd1) : 3'd1;
  assign take     = convValid && (filterOff || same_nxt == 3'(AGREE));

  // run tracker and result latch
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      last_r      <= DSCR_RST_ROW;
      same_r      <= 3'd0;
      result      <= DSCR_RST_ROW;
      resultValid <= 1'b0;
    end
    else if (convValid)
    begin
      last_r <= convData;
      same_r <= same_nxt;
      if (take)
      begin
        result      <= convData;
        resultValid <= 1'b1;
      end
    end
  end

  // filtered result needs a full run of equal conversions
  a_filter_run_len: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (convValid && !filterOff && same_nxt != 3'(AGREE)) |=> $stable(result))
    else $error("filtered result moved before four equal conversions");
  a_filter_bypass: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (convValid && filterOff) |=> result == $past(convData))
    else $error("unfiltered result missed a conversion");
endmodule
`default_nettype wire

// >>> design/dscr_pkg.sv
// constants and carrier types of the bias controller register bank
// assumes one system clock; bus framing is done outside this block
package dscr_pkg;

  // register byte addresses
  localparam logic [7:0] DSCR_ADDR_CTRL0    = 8'h80;
  localparam logic [7:0] DSCR_ADDR_ROW1     = 8'h81;
  localparam logic [7:0] DSCR_ADDR_ROW2     = 8'h82;
  localparam logic [7:0] DSCR_ADDR_DAC1     = 8'h83;
  localparam logic [7:0] DSCR_ADDR_DAC2     = 8'h84;
  localparam logic [7:0] DSCR_ADDR_SRCCFG   = 8'h85;
  localparam logic [7:0] DSCR_ADDR_WRENA    = 8'h86;
  localparam logic [7:0] DSCR_ADDR_STATUS   = 8'h87;

  // table base addresses
  localparam logic [7:0] DSCR_FIRST_LOOKUP_TABLE_BASE     = 8'h90;
  localparam logic [7:0] DSCR_SECOND_LOOKUP_TABLE_BASE     = 8'hd0;

  // control register zero field positions
  localparam int DSCR_C0_INSEL_BIT          = 1;
  localparam int DSCR_C0_REFSEL_BIT         = 2;
  localparam int DSCR_C0_FILTOFF_BIT        = 3;
  localparam int DSCR_C0_VOLSEL_BIT         = 7;

  // source configuration field positions
  localparam int DSCR_CFG_RANGE1_LSB        = 0;
  localparam int DSCR_CFG_RANGE2_LSB        = 2;
  localparam int DSCR_CFG_T1SEL_BIT         = 4;
  localparam int DSCR_CFG_D1SEL_BIT         = 5;
  localparam int DSCR_CFG_T2SEL_BIT         = 6;
  localparam int DSCR_CFG_D2SEL_BIT         = 7;

  // write enable register and status layout
  localparam int DSCR_WEL_BIT               = 7;
  localparam logic [7:0] DSCR_WEL_SET_VAL   = 8'h80;
  localparam logic [7:0] DSCR_WEL_CLR_VAL   = 8'h00;
  localparam int DSCR_STAT_RES_LSB          = 2;

  // reset values
  localparam logic [7:0] DSCR_RST_BYTE      = 8'h00;
  localparam logic [5:0] DSCR_RST_ROW       = 6'h00;

  // identical conversions needed by the agreement filter
  localparam int DSCR_AGREE_COUNT           = 4;

  // full-scale range codes
  typedef enum logic [1:0] {
    DSCR_RANGE_EXT = 2'b00,
    DSCR_RANGE_LOW = 2'b01,
    DSCR_RANGE_MID = 2'b10,
    DSCR_RANGE_HIGH = 2'b11
  } dscr_range_e;

  // byte request from the serial front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } dscr_req_s;

  // answer to the serial front end
  typedef struct packed {
    logic       ack;
    logic       nak;
    logic       rdValid;
    logic [7:0] rdData;
  } dscr_ans_s;

endpackage

// >>> design/dscr_regs.sv
// control and status registers of the bias controller
// assumes a serial front end issuing one-cycle byte requests on clk_sys,
// table memory answering combinationally and converter strobes on clk_sys
`timescale 1ns/1ps
`default_nettype none
module dscr_regs
(
  input  wire logic                clk_sys,
  input  wire logic                arst_n,
  input  wire dscr_pkg::dscr_req_s req,
  output dscr_pkg::dscr_ans_s      ans,
  input  wire logic                convValid,
  input  wire logic [5:0]          convData,
  input  wire logic [7:0]          lut1Data,
  input  wire logic [7:0]          lut2Data,
  output logic [7:0]               lut1Addr,
  output logic [7:0]               lut2Addr,
  output logic [7:0]               dac1Byte,
  output logic [7:0]               dac2Byte,
  output dscr_pkg::dscr_range_e    range1,
  output dscr_pkg::dscr_range_e    range2,
  output logic                     refExternal,
  output logic                     inputSensePin,
  output logic                     volatileSelect,
  output logic                     nvStore
);
  import dscr_pkg::*;

  // table byte address from base and row
  function automatic logic [7:0] tableAddr(input logic [7:0] base, input logic [5:0] row);
    tableAddr = base + {2'b00, row};
  endfunction

  logic [7:0] ctrl0_r;
  logic [5:0] row1_r;
  logic [5:0] row2_r;
  logic [7:0] dac1Direct_r;
  logic [7:0] dac2Direct_r;
  logic [7:0] srcCfg_r;
  logic       wel_r;
  dscr_ans_s  ans_r;
  dscr_ans_s  ans_nxt;
  logic [7:0] lut1Addr_r;
  logic [7:0] lut2Addr_r;
  logic [7:0] dac1Byte_r;
  logic [7:0] dac2Byte_r;
  logic       nvStore_r;
  logic [5:0] adcResult;
  logic       adcValid;

  // converter agreement filter
  dscr_adc_filter u_filter
  (
    .clk_sys     (clk_sys),
    .arst_n      (arst_n),
    .convValid   (convValid),
    .convData    (convData),
    .filterOff   (ctrl0_r[DSCR_C0_FILTOFF_BIT]),
    .result      (adcResult),
    .resultValid (adcValid)
  );

  // request decode
  wire        hitWrEna   = req.addr == DSCR_ADDR_WRENA;
  wire        wrAllowed  = wel_r || hitWrEna;
  wire        wrDo       = req.wr && wrAllowed;
  wire        wrCtrl0    = wrDo && req.addr == DSCR_ADDR_CTRL0;
  wire        wrRow1     = wrDo && req.addr == DSCR_ADDR_ROW1;
  wire        wrRow2     = wrDo && req.addr == DSCR_ADDR_ROW2;
  wire        wrDac1     = wrDo && req.addr == DSCR_ADDR_DAC1;
  wire        wrDac2     = wrDo && req.addr == DSCR_ADDR_DAC2;
  wire        wrSrcCfg   = wrDo && req.addr == DSCR_ADDR_SRCCFG;
  wire        welSet     = req.wr && hitWrEna && req.data == DSCR_WEL_SET_VAL;
  wire        welClr     = req.wr && hitWrEna && req.data == DSCR_WEL_CLR_VAL;
  wire        volSel     = ctrl0_r[DSCR_C0_VOLSEL_BIT];
  wire        nvWrite    = wrCtrl0 || wrSrcCfg || ((wrRow1 || wrRow2 || wrDac1 || wrDac2) && !volSel);

  // source selects
  wire        d1Sel      = srcCfg_r[DSCR_CFG_D1SEL_BIT];
  wire        d2Sel      = srcCfg_r[DSCR_CFG_D2SEL_BIT];
  wire        t1Sel      = srcCfg_r[DSCR_CFG_T1SEL_BIT];
  wire        t2Sel      = srcCfg_r[DSCR_CFG_T2SEL_BIT];

  // table rows and addresses
  wire [5:0]  row1       = t1Sel ? row1_r : adcResult;
  wire [5:0]  row2       = t2Sel ? row2_r : adcResult;
  wire [7:0]  lut1Addr_nxt = tableAddr(DSCR_FIRST_LOOKUP_TABLE_BASE, row1);
  wire [7:0]  lut2Addr_nxt = tableAddr(DSCR_SECOND_LOOKUP_TABLE_BASE, row2);
  wire        row1Ok     = t1Sel || adcValid;
  wire        row2Ok     = t2Sel || adcValid;

  // DAC input bytes, rebuilt every cycle
  wire [7:0]  dac1Byte_nxt = d1Sel ? dac1Direct_r : (row1Ok ? lut1Data : DSCR_RST_BYTE);
  wire [7:0]  dac2Byte_nxt = d2Sel ? dac2Direct_r : (row2Ok ? lut2Data : DSCR_RST_BYTE);

  // read mux; reserved bits read zero, except in control register zero, which reads back the whole byte as written
  wire [7:0]  rdStatus   = {adcResult, 2'b00};
  wire [7:0]  rdWrEna    = {wel_r, 7'h00};
  wire [7:0]  rdMux      = (req.addr == DSCR_ADDR_CTRL0)  ? ctrl0_r :
                           (req.addr == DSCR_ADDR_ROW1)   ? {2'b00, row1_r} :
                           (req.addr == DSCR_ADDR_ROW2)   ? {2'b00, row2_r} :
                           (req.addr == DSCR_ADDR_DAC1)   ? dac1Direct_r :
                           (req.addr == DSCR_ADDR_DAC2)   ? dac2Direct_r :
                           (req.addr == DSCR_ADDR_SRCCFG) ? srcCfg_r :
                           (req.addr == DSCR_ADDR_WRENA)  ? rdWrEna :
                           (req.addr == DSCR_ADDR_STATUS) ? rdStatus : DSCR_RST_BYTE;

  // answer assembly
  always_comb
  begin
    ans_nxt         = ans_r;
    ans_nxt.ack     = wrDo || (req.rd && !req.wr);
    ans_nxt.nak     = req.wr && !wrAllowed;
    ans_nxt.rdValid = req.rd && !req.wr;
    if (req.rd && !req.wr)
    begin
      ans_nxt.rdData = rdMux;
    end
  end

  // control registers
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl0_r      <= DSCR_RST_BYTE;
      row1_r       <= DSCR_RST_ROW;
      row2_r       <= DSCR_RST_ROW;
      dac1Direct_r <= DSCR_RST_BYTE;
      dac2Direct_r <= DSCR_RST_BYTE;
      srcCfg_r     <= DSCR_RST_BYTE;
    end
    else
    begin
      if (wrCtrl0)  ctrl0_r      <= req.data;
      if (wrRow1)   row1_r       <= req.data[5:0];
      if (wrRow2)   row2_r       <= req.data[5:0];
      if (wrDac1)   dac1Direct_r <= req.data;
      if (wrDac2)   dac2Direct_r <= req.data;
      if (wrSrcCfg) srcCfg_r     <= req.data;
    end
  end

  // write enable latch; other values leave it alone
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      wel_r <= 1'b0;
    else if (welSet)
      wel_r <= 1'b1;
    else if (welClr)
      wel_r <= 1'b0;
  end

  // registered outputs
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ans_r      <= '0;
      lut1Addr_r <= DSCR_FIRST_LOOKUP_TABLE_BASE;
      lut2Addr_r <= DSCR_SECOND_LOOKUP_TABLE_BASE;
      dac1Byte_r <= DSCR_RST_BYTE;
      dac2Byte_r <= DSCR_RST_BYTE;
      nvStore_r  <= 1'b0;
    end
    else
    begin
      ans_r      <= ans_nxt;
      lut1Addr_r <= lut1Addr_nxt;
      lut2Addr_r <= lut2Addr_nxt;
      dac1Byte_r <= dac1Byte_nxt;
      dac2Byte_r <= dac2Byte_nxt;
      nvStore_r  <= nvWrite;
    end
  end

  // output drive
  assign ans            = ans_r;
  assign lut1Addr       = lut1Addr_r;
  assign lut2Addr       = lut2Addr_r;
  assign dac1Byte       = dac1Byte_r;
  assign dac2Byte       = dac2Byte_r;
  assign nvStore        = nvStore_r;
  assign range1         = dscr_range_e'(srcCfg_r[DSCR_CFG_RANGE1_LSB +: 2]);
  assign range2         = dscr_range_e'(srcCfg_r[DSCR_CFG_RANGE2_LSB +: 2]);
  assign refExternal    = ctrl0_r[DSCR_C0_REFSEL_BIT];
  assign inputSensePin  = ctrl0_r[DSCR_C0_INSEL_BIT];
  assign volatileSelect = volSel;

  // checks on source selection and table addressing
  a_dac1_direct: assert property (@(posedge clk_sys) disable iff (!arst_n)
    d1Sel |=> dac1Byte == $past(dac1Direct_r))
    else $error("first DAC not fed from direct byte");
  a_dac2_direct: assert property (@(posedge clk_sys) disable iff (!arst_n)
    d2Sel |=> dac2Byte == $past(dac2Direct_r))
    else $error("second DAC not fed from direct byte");
  a_dac1_table: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!d1Sel && row1Ok) |=> dac1Byte == $past(lut1Data))
    else $error("first DAC not fed from table");
  a_dac2_table: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!d2Sel && row2Ok) |=> dac2Byte == $past(lut2Data))
    else $error("second DAC not fed from table");
  a_dac_hold_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!d2Sel && !t2Sel && !adcValid) |=> dac2Byte == 8'h00)
    else $error("second DAC left 00h before a valid result");
  a_dac1_hold_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!d1Sel && !t1Sel && !adcValid) |=> dac1Byte == 8'h00)
    else $error("first DAC left 00h before a valid result");
  a_row_address: assert property (@(posedge clk_sys) disable iff (!arst_n)
    1'b1 |=> lut2Addr == 8'(8'hd0 + {2'b00, $past(row2)}))
    else $error("second table address wrong");
  a_row1_source: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!t1Sel) |=> lut1Addr == 8'(8'h90 + {2'b00, $past(adcResult)}))
    else $error("first table not addressed by converter");
  a_row1_direct: assert property (@(posedge clk_sys) disable iff (!arst_n)
    t1Sel |=> lut1Addr == 8'(8'h90 + {2'b00, $past(row1_r)}))
    else $error("first table not addressed by row bits");
  a_row2_source: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!t2Sel) |=> lut2Addr == 8'(8'hd0 + {2'b00, $past(adcResult)}))
    else $error("second table not addressed by converter");

  // checks on write gating, stored bytes and the latch
  a_write_gated: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (req.wr && !wel_r && !hitWrEna) |=> ans.nak && !ans.ack && $stable(srcCfg_r))
    else $error("write taken while latch clear");
  a_write_abort_dac: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (req.wr && !wel_r && req.addr == 8'h83) |=> $stable(dac1Direct_r) && !nvStore)
    else $error("direct byte written while latch clear");
  a_write_answer: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (req.wr && wel_r) |=> ans.ack && !ans.nak && !ans.rdValid)
    else $error("enabled write not acknowledged");
  a_dac1_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (req.wr && wel_r && req.addr == 8'h83) |=> dac1Direct_r == $past(req.data))
    else $error("first direct byte not written");
  a_dac2_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (req.wr && wel_r && req.addr == 8'h84) |=> dac2Direct_r == $past(req.data))
    else $error("second direct byte not written");
  a_srccfg_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (req.wr && wel_r && req.addr == 8'h85) |=> srcCfg_r == $past(req.data) && nvStore)
    else $error("source configuration not stored");
  a_nv_follow_sel: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (req.wr && wel_r && (req.addr == 8'h83 || req.addr == 8'h84)) |=> nvStore == !$past(volSel))
    else $error("direct byte volatility wrong");
  a_range_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (req.wr && wel_r && req.addr == 8'h85) |=>
      range1 == dscr_range_e'($past(req.data[1:0])) && range2 == dscr_range_e'($past(req.data[3:2])))
    else $error("range fields misplaced");
  a_ctrl0_selects: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (req.wr && wel_r && req.addr == 8'h80) |=>
      refExternal == $past(req.data[2]) && inputSensePin == $past(req.data[1]))
    else $error("reference or input select misplaced");
  a_wel_set_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (req.wr && hitWrEna && req.data == 8'h80) |=> wel_r ##1 (wel_r || $past(welClr)))
    else $error("write latch not set by 80h");
  a_wel_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (req.wr && hitWrEna && req.data == 8'h00) |=> !wel_r)
    else $error("write latch not cleared by 00h");
  a_wel_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (wel_r && !(req.wr && hitWrEna && req.data == 8'h00)) |=> wel_r)
    else $error("write latch dropped without clear");
  a_wel_other_val: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (req.wr && hitWrEna && req.data != 8'h80 && req.data != 8'h00) |=> $stable(wel_r))
    else $error("write latch moved on other value");

  // checks on reads
  a_wel_reserved: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (req.rd && !req.wr && req.addr == 8'h86) |=> ans.rdData[6:0] == 7'h00)
    else $error("reserved latch bits not zero");
  a_read_answer: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (req.rd && !req.wr) |=> ans.ack && ans.rdValid && !ans.nak)
    else $error("read not answered");
  a_status_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (req.rd && !req.wr && req.addr == 8'h87) |=> ans.rdValid && ans.rdData == {$past(adcResult), 2'b00})
    else $error("status read wrong");

  // main scenarios
  c_direct_dac: cover property (@(posedge clk_sys) disable iff (!arst_n) d1Sel && d2Sel);
  c_wel_then_write: cover property (@(posedge clk_sys) disable iff (!arst_n) welSet ##[1:20] wrSrcCfg);
  c_filtered_valid: cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(adcValid));
  c_table_direct: cover property (@(posedge clk_sys) disable iff (!arst_n) t1Sel && t2Sel && !d1Sel && !d2Sel);
  c_write_refused: cover property (@(posedge clk_sys) disable iff (!arst_n) (req.wr && !wrAllowed) ##1 ans.nak);
endmodule
`default_nettype wire

// >>> verif/dscr_host_model.sv
// host model issuing single byte requests to the register bank
// assumes the bank answers exactly one cycle after it takes a request
`timescale 1ns/1ps
`default_nettype none
module dscr_host_model
(
  input  wire logic                clk_sys,
  output dscr_pkg::dscr_req_s      req,
  input  wire dscr_pkg::dscr_ans_s ans
);
  import dscr_pkg::*;

  initial req = '0;

  // one transfer: request stands one cycle, answer taken in the next
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output dscr_ans_s r);
    @(negedge clk_sys);
    req = {w, !w, a, d};
    @(negedge clk_sys);
    r = ans;
    req = {1'b0, 1'b0, ~a, ~d}; // idle fields show stale inverse
  endtask

  // latch set before any other write, cleared by a zero byte
  task automatic write_enable_latch(input logic on);
    dscr_ans_s r;
    xfer(1'b1, DSCR_ADDR_WRENA, on ? DSCR_WEL_SET_VAL : DSCR_WEL_CLR_VAL, r);
  endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the bias controller register bank
// assumes the host model drives requests; table memory is modelled here
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dscr_pkg::*;
  logic        clk_sys;
  logic        arst_n;
  dscr_req_s   req;
  dscr_ans_s   ans;
  logic        convValid;
  logic [5:0]  convData;
  logic [7:0]  lut1Data;
  logic [7:0]  lut2Data;
  logic [7:0]  lut1Addr;
  logic [7:0]  lut2Addr;
  logic [7:0]  dac1Byte;
  logic [7:0]  dac2Byte;
  dscr_range_e range1;
  dscr_range_e range2;
  logic        refExternal;
  logic        inputSensePin;
  logic        volatileSelect;
  logic        nvStore;
  logic [7:0]  v;
  int          n_fail;
  int          n_tests;

  // table memory pattern, distinct per table
  assign lut1Data = lut1Addr ^ 8'h5a;
  assign lut2Data = lut2Addr ^ 8'h33;

  dscr_regs dut (.clk_sys(clk_sys), .arst_n(arst_n), .req(req), .ans(ans), .convValid(convValid),
    .convData(convData), .lut1Data(lut1Data), .lut2Data(lut2Data), .lut1Addr(lut1Addr),
    .lut2Addr(lut2Addr), .dac1Byte(dac1Byte), .dac2Byte(dac2Byte), .range1(range1), .range2(range2),
    .refExternal(refExternal), .inputSensePin(inputSensePin), .volatileSelect(volatileSelect),
    .nvStore(nvStore));
  dscr_host_model host (.clk_sys(clk_sys), .req(req), .ans(ans));

  // 200 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // write leaves {ack, nak} in v, read leaves data in v only if valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    dscr_ans_s r;
    host.xfer(1'b1, a, d, r);
    v = {6'h00, r.ack, r.nak};
  endtask
  task automatic rd(input logic [7:0] a);
    dscr_ans_s r;
    host.xfer(1'b0, a, 8'h00, r);
    v = r.rdValid ? r.rdData : 8'hxx;
  endtask

  // n conversions of one value, then time for result, table and dac stages
  task automatic conv(input logic [5:0] d, input int n);
    repeat (n)
    begin
      @(negedge clk_sys);
      convValid = 1'b1;
      convData = d;
      @(negedge clk_sys);
      convValid = 1'b0;
      convData = ~d;
    end
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic t_reset;
    check(dac1Byte, 8'h00);
    check(dac2Byte, 8'h00);
    check(lut1Addr, 8'h90);
    check(lut2Addr, 8'hd0);
    check({4'h0, range1, range2}, 8'h00);
    check({5'h00, volatileSelect, refExternal, inputSensePin}, 8'h00);
    rd(DSCR_ADDR_WRENA);
    check(v, 8'h00);
    $display("t_reset done");
  endtask

  task automatic t_filter;
    conv(6'h2a, 3);
    rd(DSCR_ADDR_STATUS);
    check(v, 8'h00);
    conv(6'h15, 1);
    conv(6'h2a, 3);
    rd(DSCR_ADDR_STATUS);
    check(v, 8'h00);
    conv(6'h2a, 1);
    rd(DSCR_ADDR_STATUS);
    check(v, {6'h2a, 2'b00});
    check(lut1Addr, 8'h90 + 8'h2a);
    check(lut2Addr, 8'hd0 + 8'h2a);
    check(dac1Byte, (8'h90 + 8'h2a) ^ 8'h5a);
    check(dac2Byte, (8'hd0 + 8'h2a) ^ 8'h33);
    $display("t_filter done");
  endtask

  task automatic t_wel;
    wr(DSCR_ADDR_SRCCFG, 8'hff);
    check(v, 8'h01);
    rd(DSCR_ADDR_SRCCFG);
    check(v, 8'h00);
    host.write_enable_latch(1'b1);
    rd(DSCR_ADDR_WRENA);
    check(v, 8'h80);
    wr(DSCR_ADDR_WRENA, 8'h81);
    check(v, 8'h02);
    rd(DSCR_ADDR_WRENA);
    check(v, 8'h80);
    wr(DSCR_ADDR_STATUS, 8'h00);
    rd(DSCR_ADDR_STATUS);
    check(v, {6'h2a, 2'b00});
    host.write_enable_latch(1'b0);
    rd(DSCR_ADDR_WRENA);
    check(v, 8'h00);
    wr(DSCR_ADDR_DAC1, 8'h77);
    check(v, 8'h01);
    host.write_enable_latch(1'b1);
    $display("t_wel done");
  endtask

  task automatic t_range;
    for (int c = 0; c < 4; c++)
    begin
      wr(DSCR_ADDR_SRCCFG, {4'h0, 2'(3 - c), 2'(c)});
      check({6'h00, range1}, 8'(c));
      check({6'h00, range2}, 8'(3 - c));
      rd(DSCR_ADDR_SRCCFG);
      check(v, {4'h0, 2'(3 - c), 2'(c)});
    end
    $display("t_range done");
  endtask

  task automatic t_direct;
    wr(DSCR_ADDR_DAC1, 8'ha5);
    wr(DSCR_ADDR_DAC2, 8'h3c);
    check({7'h00, nvStore}, 8'h01);
    wr(DSCR_ADDR_ROW1, 8'h05);
    wr(DSCR_ADDR_ROW2, 8'h55);
    wr(DSCR_ADDR_SRCCFG, 8'h50);
    check({7'h00, nvStore}, 8'h01);
    repeat (2) @(negedge clk_sys);
    check(lut1Addr, 8'h90 + 8'h05);
    check(lut2Addr, 8'hd0 + 8'h15);
    check(dac1Byte, (8'h90 + 8'h05) ^ 8'h5a);
    check(dac2Byte, (8'hd0 + 8'h15) ^ 8'h33);
    wr(DSCR_ADDR_SRCCFG, 8'hf0);
    repeat (2) @(negedge clk_sys);
    check(dac1Byte, 8'ha5);
    check(dac2Byte, 8'h3c);
    rd(DSCR_ADDR_DAC2);
    check(v, 8'h3c);
    wr(DSCR_ADDR_SRCCFG, 8'h20);
    repeat (2) @(negedge clk_sys);
    check(dac1Byte, 8'ha5);
    check(dac2Byte, (8'hd0 + 8'h2a) ^ 8'h33);
    $display("t_direct done");
  endtask

  task automatic t_ctrl0;
    wr(DSCR_ADDR_CTRL0, 8'h8e);
    check({5'h00, volatileSelect, refExternal, inputSensePin}, 8'h07);
    wr(DSCR_ADDR_DAC1, 8'h5a);
    check({7'h00, nvStore}, 8'h00);
    @(negedge clk_sys);
    check(dac1Byte, 8'h5a);
    conv(6'h3f, 1);
    rd(DSCR_ADDR_STATUS);
    check(v, 8'hfc);
    $display("t_ctrl0 done");
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // main sequence after a 16 cycle reset
  initial
  begin
    arst_n = 1'b0;
    convValid = 1'b0;
    convData = 6'h00;
    n_fail = 0;
    n_tests = 0;
    repeat (16) @(negedge clk_sys);
    arst_n = 1'b1;
    t_reset;
    t_filter;
    t_wel;
    t_range;
    t_direct;
    t_ctrl0;
    end_of_test;
  end

  // watchdog well beyond the expected run of about 130 cycles
  initial
  begin
    #20000;
    n_fail++;
    $display("watchdog expired");
    end_of_test;
  end
endmodule
`default_nettype wire
